/* File: logic/cbr_list_scheduler_reset.v */
// rate-strobe list scheduler for priorities 3 and 2 with reset sequencing
`timescale 1ns/10ps
`default_nettype none
`include "cbr_sched_regs.vh"
// Summary of operation
// - two strobes, priority 3 and 2, sharing one list head and length for the one output (0-7) set by out_sel
// - schedule one cell per strobe falling edge once prior cell finished
// - each list holds up to 8191 entries, walked in link order from head
// - strobe high eight or more clocks after a full pass returns pointer to list head
// - slow strobes high over 8 clocks schedule exactly one cell per fall
// - after the last connection the pointer wraps to the first
// - 8191 clocks of internal reset before acknowledge shows completion
// - reset output stays high until the start command arrives
// - start command 0c enables the device after initialization
// - next cell waits until the previous one has been serviced
// - long high restarts list only when every connection was serviced
module cbr_list_scheduler_reset #(
	parameter PW = 13,
	parameter INIT_CYCLES = 8191
) (
	input wire clk,
	input wire sys_rst,
	input wire reset_in,
	input wire rate_strobe_prio3,
	input wire rate_strobe_prio2,
	input wire [2:0] out_sel,
	input wire [PW-1:0] list_head,
	input wire [PW-1:0] list_len,
	input wire [PW-1:0] link_next_p3,
	input wire [PW-1:0] link_next_p2,
	input wire serviced_p3,
	input wire serviced_p2,
	input wire cmd_valid,
	input wire [7:0] cmd_code,
	output reg reset_out,
	output reg reset_ack,
	output reg enabled,
	output reg sched_p3,
	output reg sched_p2,
	output reg [PW-1:0] conn_ptr_p3,
	output reg [PW-1:0] conn_ptr_p2,
	output reg [2:0] sched_out
);
	localparam ST_IDLE = 2'd0;
	localparam ST_INIT = 2'd1;
	localparam ST_WAIT_START = 2'd2;
	localparam ST_RUN = 2'd3;
	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg rin1_ff;
	reg rin2_ff;
	reg [12:0] init_cnt_ff;
	reg [2:0] out_ff;
	reg [PW-1:0] head_ff;
	reg [PW-1:0] len_ff;
	wire run;
	wire run_next;
	wire ack_next;
	wire init_last;
	wire start_cmd;
	wire [1:0] strobe_pins;
	wire [1:0] serviced_bus;
	wire [2*PW-1:0] link_bus;
	wire [2*PW-1:0] ptr_bus;
	wire [1:0] pulse;
	genvar g;
	assign run = state_ff == ST_RUN;
	assign start_cmd = cmd_valid && cmd_code == `START_CMD_CODE;
	assign init_last = init_cnt_ff == INIT_CYCLES[12:0] - 13'd1;
	// flags follow the next state, gated so a fresh reset_in wins at once
	assign run_next = !rin2_ff && nxt_state == ST_RUN;
	assign ack_next = !rin2_ff && (nxt_state == ST_WAIT_START || nxt_state == ST_RUN);
	// index 1 carries priority 3, index 0 priority 2
	assign strobe_pins = {rate_strobe_prio3, rate_strobe_prio2};
	assign serviced_bus = {serviced_p3, serviced_p2};
	assign link_bus = {link_next_p3, link_next_p2};
	// list setup is latched in the idle states; one output shared by both walkers at a time
	always @(posedge clk)
	begin
		if (sys_rst)
			out_ff <= 3'd0;
		else if (!run)
			out_ff <= out_sel;
	end
	// head and length frozen while running so a pass never sees them move
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			head_ff <= {PW{1'b0}};
			len_ff <= {PW{1'b0}};
		end
		else if (!run)
		begin
			head_ff <= list_head;
			len_ff <= list_len;
		end
	end
	// both walkers share the latched head and length
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : gen_walk
			strobe_list_walker #(.PW(PW)) walk (
				.clk(clk),
				.sys_rst(sys_rst),
				.enable(run),
				.strobe_pin(strobe_pins[g]),
				.list_head(head_ff),
				.link_next(link_bus[g*PW +: PW]),
				.list_len(len_ff),
				.cell_serviced(serviced_bus[g]),
				.sched_pulse_ff(pulse[g]),
				.conn_ptr_ff(ptr_bus[g*PW +: PW]),
				.busy_ff(),
				.restart_ff()
			);
		end
	endgenerate
	always @*
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE:
			begin
				if (!rin2_ff)
					nxt_state = ST_INIT;
			end
			ST_INIT:
			begin
				if (init_last)
					nxt_state = ST_WAIT_START;
			end
			ST_WAIT_START:
			begin
				if (start_cmd)
					nxt_state = ST_RUN;
			end
			ST_RUN:
			begin
				nxt_state = ST_RUN;
			end
			default:
			begin
				nxt_state = ST_IDLE;
			end
		endcase
	end
	// pin synchroniser; reset value high keeps the sequence idle until reset_in is seen low
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			rin1_ff <= 1'b1;
			rin2_ff <= 1'b1;
		end
		else
		begin
			rin1_ff <= reset_in;
			rin2_ff <= rin1_ff;
		end
	end
	// reset_in high restarts the whole sequence; holding time is the driver's job
	always @(posedge clk)
	begin
		if (sys_rst)
			state_ff <= ST_IDLE;
		else if (rin2_ff)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end
	// counter runs only in its state, so any reset_in pulse restarts the full count
	always @(posedge clk)
	begin
		if (sys_rst)
			init_cnt_ff <= 13'd0;
		else if (state_ff == ST_INIT && !rin2_ff)
			init_cnt_ff <= init_cnt_ff + 13'd1;
		else
			init_cnt_ff <= 13'd0;
	end
	always @(posedge clk)
	begin
		if (sys_rst)
			reset_ack <= 1'b0;
		else
			reset_ack <= ack_next;
	end
	// reset_out and enabled are complements, both released by the start command
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			reset_out <= 1'b1;
			enabled <= 1'b0;
		end
		else
		begin
			reset_out <= !run_next;
			enabled <= run_next;
		end
	end
	// outputs sit one register behind the walkers so pulse and pointer line up
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			sched_p3 <= 1'b0;
			sched_p2 <= 1'b0;
			conn_ptr_p3 <= {PW{1'b0}};
			conn_ptr_p2 <= {PW{1'b0}};
			sched_out <= 3'd0;
		end
		else
		begin
			sched_p3 <= pulse[1];
			sched_p2 <= pulse[0];
			conn_ptr_p3 <= ptr_bus[2*PW-1:PW];
			conn_ptr_p2 <= ptr_bus[PW-1:0];
			sched_out <= out_ff;
		end
	end
endmodule
`default_nettype wire

/* File: logic/cbr_sched_regs.vh */
// constants for the rate-strobe list scheduler and reset sequencer
`ifndef CBR_SCHED_REGS_VH
`define CBR_SCHED_REGS_VH
`define LONG_HIGH_CYCLES 4'd8
`define RESET_IN_HOLD 4'd8
`define INTERNAL_RESET_CYCLES 13'd8191
`define START_CMD_CODE 8'h0c
`define NUM_OUTPUTS 8
`define LIST_ENTRIES 8192
`define SERVICE_WAIT_MAX 7'd65
`endif

/* File: logic/strobe_list_walker.v */
// one rate strobe: edge detect, long-high detect, list pointer walk
`timescale 1ns/10ps
`default_nettype none
`include "cbr_sched_regs.vh"
module strobe_list_walker #(
	parameter PW = 13
) (
	input wire clk,
	input wire sys_rst,
	input wire enable,
	input wire strobe_pin,
	input wire [PW-1:0] list_head,
	input wire [PW-1:0] link_next,
	input wire [PW-1:0] list_len,
	input wire cell_serviced,
	output reg sched_pulse_ff,
	output reg [PW-1:0] conn_ptr_ff,
	output reg busy_ff,
	output reg restart_ff
);
	reg sync1_ff;
	reg sync2_ff;
	reg prev_ff;
	reg [3:0] high_cnt_ff;
	reg [PW:0] done_cnt_ff;
	wire fall;
	wire long_high;
	wire all_done;
	assign fall = prev_ff & ~sync2_ff;
	// count saturates so a very long high restarts only once
	assign long_high = sync2_ff && high_cnt_ff == `LONG_HIGH_CYCLES - 4'd1;
	assign all_done = done_cnt_ff >= {1'b0, list_len};
	always @(posedge clk)
	begin
		if (sys_rst)
		begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			prev_ff <= 1'b0;
			high_cnt_ff <= 4'd0;
			done_cnt_ff <= {(PW+1){1'b0}};
			sched_pulse_ff <= 1'b0;
			conn_ptr_ff <= {PW{1'b0}};
			busy_ff <= 1'b0;
			restart_ff <= 1'b0;
		end
		else
		begin
			sync1_ff <= strobe_pin;
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
			sched_pulse_ff <= 1'b0;
			restart_ff <= 1'b0;
			if (!sync2_ff)
				high_cnt_ff <= 4'd0;
			else if (high_cnt_ff != `LONG_HIGH_CYCLES)
				high_cnt_ff <= high_cnt_ff + 4'd1;
			if (busy_ff && cell_serviced)
			begin
				busy_ff <= 1'b0;
				if (all_done)
					conn_ptr_ff <= list_head;
				else
					conn_ptr_ff <= link_next;
			end
			if (!enable)
			begin
				conn_ptr_ff <= list_head;
				done_cnt_ff <= {(PW+1){1'b0}};
			end
			else if (long_high && all_done && !busy_ff)
			begin
				conn_ptr_ff <= list_head;
				done_cnt_ff <= {(PW+1){1'b0}};
				restart_ff <= 1'b1;
			end
			else if (fall && !busy_ff && !all_done)
			begin
				sched_pulse_ff <= 1'b1;
				busy_ff <= 1'b1;
				done_cnt_ff <= done_cnt_ff + {{PW{1'b0}}, 1'b1};
			end
			else if (fall && !busy_ff && all_done)
			begin
				// wrap without a long high: start the next pass at the head
				sched_pulse_ff <= 1'b1;
				busy_ff <= 1'b1;
				done_cnt_ff <= {{PW{1'b0}}, 1'b1};
			end
		end
	end
endmodule
`default_nettype wire

/* File: bench/svc_partner.sv */
// link memory and output service model for one priority list
`timescale 1ns/10ps
`default_nettype none
module svc_partner (
	input wire logic clk,
	input wire logic sched,
	input wire logic [12:0] ptr,
	input wire logic [6:0] dly,
	output logic serviced,
	output logic [12:0] link_next
);
	int cnt = 0;
	// lists are laid out contiguously from the head
	assign link_next = ptr + 13'h1;
	always @(posedge clk)
	begin
		serviced <= (cnt == 1);
		if (sched)
			cnt <= dly;
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
endmodule
`default_nettype wire

/* File: bench/cbr_sched_properties.sv */
// port-level checks of the list scheduler and reset sequencer
`timescale 1ns/10ps
`default_nettype none
module cbr_sched_checker #(
	parameter INIT_CYCLES = 8191
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic reset_in,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic reset_out,
	input wire logic reset_ack,
	input wire logic enabled,
	input wire logic sched_p3,
	input wire logic sched_p2
);
	int lo_cnt = 0;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// slack of six covers the pin synchroniser
	always @(posedge clk)
		lo_cnt <= (sys_rst || reset_in) ? 0 : lo_cnt + 1;
	a_pulse_p3: assert property (sched_p3 |=> !sched_p3)
		else $error("sched_p3 held");
	a_pulse_p2: assert property (sched_p2 |=> !sched_p2)
		else $error("sched_p2 held");
	a_out_vs_en: assert property (reset_out != enabled)
		else $error("reset_out wrong");
	a_start_take: assert property (cmd_valid && cmd_code == 8'h0c && reset_ack && !enabled
		|-> ##[1:2] enabled) else $error("start lost");
	a_start_refuse: assert property (cmd_valid && !reset_ack |=> !enabled)
		else $error("early start");
	a_sched_en: assert property (sched_p3 || sched_p2 |-> enabled)
		else $error("sched while off");
	a_ack_delay: assert property ($rose(reset_ack)
		|-> lo_cnt >= INIT_CYCLES && lo_cnt <= INIT_CYCLES + 6) else $error("ack timing");
	a_ack_drop: assert property (reset_in [*3] |=> !reset_ack)
		else $error("ack in reset");
	cover property ($rose(enabled));
	cover property (sched_p3);
	cover property (sched_p2);
endmodule
bind cbr_list_scheduler_reset cbr_sched_checker #(.INIT_CYCLES(INIT_CYCLES)) chk (.*);
`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench for the rate-strobe list scheduler
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin logic [31:0] x_v; x_v = (e); total_checks++; if ((s) !== x_v) \
	begin error_cnt++; $display("ERROR %s exp %0h got %0h", n, x_v, s); end end
module testbench;
	logic clk = 0, sys_rst = 1, reset_in = 0, cmd_valid = 0;
	logic s[2] = '{0, 0};
	logic [2:0] out_sel = 0;
	logic [12:0] list_head = 0, list_len = 1;
	logic [7:0] cmd_code = 0;
	logic [6:0] dly = 1;
	logic [12:0] q[2][$];
	int ix[2] = '{0, 0};
	int error_cnt = 0, total_checks = 0, cyc = 0;
	wire logic serviced_p3, serviced_p2, reset_out, reset_ack, enabled, sched_p3, sched_p2;
	wire logic [12:0] conn_ptr_p3, conn_ptr_p2, link_next_p3, link_next_p2;
	wire logic [2:0] sched_out;
	cbr_list_scheduler_reset #(.INIT_CYCLES(16)) dut (.*, .rate_strobe_prio3(s[0]),
		.rate_strobe_prio2(s[1]));
	svc_partner m3 (.clk(clk), .sched(sched_p3), .ptr(conn_ptr_p3), .dly(dly),
		.serviced(serviced_p3), .link_next(link_next_p3));
	svc_partner m2 (.clk(clk), .sched(sched_p2), .ptr(conn_ptr_p2), .dly(dly),
		.serviced(serviced_p2), .link_next(link_next_p2));
	initial
		forever #12.5 clk = ~clk;
	task automatic tally_and_finish(input int extra);
		error_cnt += extra;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cmd(input logic [7:0] c, input logic exp);
		cmd_valid <= 1;
		cmd_code <= c;
		@(posedge clk);
		cmd_valid <= 0;
		repeat (2) @(posedge clk);
		#1 `CHK("enabled", exp, enabled)
		`CHK("reset_out", !exp, reset_out)
		@(posedge clk);
	endtask
	task automatic strobe(input int hi, input int lo, input int p, input bit take);
		s[p] <= 1;
		repeat (hi) @(posedge clk);
		s[p] <= 0;
		if (take)
			q[p].push_back(list_head + ix[p][12:0]);
		if (take)
			ix[p] = (ix[p] + 1) % list_len;
		repeat (lo) @(posedge clk);
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
			tally_and_finish(1);
		if (sched_p3 === 1'b1)
			`CHK("conn_ptr_p3", q[0].pop_front(), conn_ptr_p3)
		if (sched_p2 === 1'b1)
			`CHK("conn_ptr_p2", q[1].pop_front(), conn_ptr_p2)
		if (sched_p3 === 1'b1 || sched_p2 === 1'b1)
			`CHK("sched_out", out_sel, sched_out)
	end
	initial
	begin
		void'($urandom(16));
		repeat (6) @(posedge clk);
		sys_rst <= 0;
		reset_in <= 1;
		repeat (8) @(posedge clk);
		reset_in <= 0;
		list_head <= 13'($urandom_range(8000));
		list_len <= 13'($urandom_range(6, 3));
		out_sel <= 3'($urandom);
		cmd(8'h0c, 0);
		repeat (8) @(posedge clk);
		#1 `CHK("reset_ack", 1'b0, reset_ack)
		repeat (12) @(posedge clk);
		#1 `CHK("reset_ack", 1'b1, reset_ack)
		@(posedge clk);
		cmd(8'h0d, 0);
		cmd(8'h0c, 1);
		dly <= 7'($urandom_range(3, 1));
		// both priorities at once, p3 wrapping twice
		fork
			repeat (2 * list_len + 1) strobe(2, 12, 0, 1);
			repeat (list_len + 2) strobe(3, 15, 1, 1);
		join
		dly <= 7'd40;
		strobe(2, 4, 0, 1);
		strobe(2, 30, 0, 0);
		dly <= 7'd2;
		// long highs mid-list must not restart the walk
		repeat (list_len) strobe(12, 12, 0, 1);
		// second reset in mid-run: status drops, walk starts over from the head
		reset_in <= 1;
		repeat (8) @(posedge clk);
		reset_in <= 0;
		#1 `CHK("reset_ack", 1'b0, reset_ack)
		`CHK("enabled", 1'b0, enabled)
		repeat (24) @(posedge clk);
		#1 `CHK("reset_ack", 1'b1, reset_ack)
		@(posedge clk);
		ix = '{0, 0};
		cmd(8'h0c, 1);
		strobe(12, 12, 0, 1);
		repeat (20) @(posedge clk);
		`CHK("queue_left", 0, q[0].size() + q[1].size())
		tally_and_finish(0);
	end
endmodule
`default_nettype wire
